//--- hdl/acrd_map.vh
/*
 * Register map, field layout, reset values and detection limits of the
 * audio clock rate detector. Definitions only; included by acrd_top.v.
 */
`ifndef ACRD_MAP_VH
`define ACRD_MAP_VH

// Register offsets on the control port
`define ACRD_OFS_DIE_ID       8'h58
`define ACRD_OFS_RATES        8'h5B

// Field positions in detected_clock_rates
`define ACRD_RESV_BIT         7
`define ACRD_RATE_MSB         6
`define ACRD_RATE_LSB         4
`define ACRD_RATIO_MSB        3
`define ACRD_RATIO_LSB        0

// Reset values
`define ACRD_RATES_RST        8'h00
`define ACRD_RATE_RST         3'h0
`define ACRD_RATIO_RST        4'h0

// Sample rate codes
`define ACRD_RATE_ERR         3'h0
`define ACRD_RATE_8K          3'h1
`define ACRD_RATE_16K         3'h2
`define ACRD_RATE_32_48K      3'h3
`define ACRD_RATE_88_96K      3'h4
`define ACRD_RATE_176_192K    3'h5
`define ACRD_RATE_384K        3'h6

// Ratio codes
`define ACRD_RATIO_ERR        4'h0
`define ACRD_RATIO_LAST       4'hE

// Timing: clock period and master clock ceiling
`define ACRD_CLK_PERIOD_NS    100
`define ACRD_MCLK_MAX_MHZ     50
`define ACRD_NS_PER_US        1000

// Window length in clk cycles is reduced to units of 2**UNIT_SHIFT cycles
`define ACRD_UNIT_SHIFT       5

// Window lengths (64 frames) in units, per supported rate band, +-4 percent
`define ACRD_U8K_LO           12'd2400
`define ACRD_U8K_HI           12'd2600
`define ACRD_U16K_LO          12'd1200
`define ACRD_U16K_HI          12'd1300
`define ACRD_U48K_LO          12'd400
`define ACRD_U48K_HI          12'd650
`define ACRD_U96K_LO          12'd200
`define ACRD_U96K_HI          12'd236
`define ACRD_U192K_LO         12'd100
`define ACRD_U192K_HI         12'd118
`define ACRD_U384K_LO         12'd50
`define ACRD_U384K_HI         12'd54
`define ACRD_TIMEOUT_UNITS    12'd2800

// Least ratio that leaves the DSP enough cycles when the PLL is off
`define ACRD_MIN_RATIO_NO_PLL 12'd64

`endif

//--- hdl/acrd_sync_edge.v
/*
 * Two-flop synchronisers with rising-edge detect for asynchronous pins.
 * Assumes pins toggle slower than half the clk rate.
 */
`timescale 1ns/10ps
module acrd_sync_edge #(
  parameter WIDTH = 2
) (
  input  wire             clk,      // System clock
  input  wire             reset_n,  // Async reset, active low
  input  wire [WIDTH-1:0] pin_in,   // Asynchronous pin levels
  output wire [WIDTH-1:0] rise_out  // One-cycle pulse per rising edge
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      reg last_reg;
      // Only the second stage and its delayed copy feed the edge detect
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          last_reg <= 1'b0;
        end else begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end
      assign rise_out[i] = sync_reg & ~last_reg;
    end
  endgenerate

endmodule

//--- hdl/acrd_top.v
/*
 * Audio clock rate detector: measures the frame clock and a prescaled
 * master clock, reports sample rate and ratio codes, flags invalid clocks,
 * and serves the die identification and detected rates registers.
 * Assumes the master clock arrives divided by MCLK_PRESCALE and that the
 * register port is driven synchronously to clk.
 */
// Operation
// - Sample rate code sits in bits 6..4, codes 001 to 110.
// - Sample rate outside every band reports code 000.
// - Ratio code in bits 3..0, 0001..0111 for 32 to 384 fs.
// - Ratio not permitted reports code 0000.
// - Clock error may rise with a valid ratio for bad combinations.
// - PLL off needs a ratio high enough for DSP, else clock invalid.
// - Master clock at or above 50 MHz is an invalid clock.
// - Ratio codes 1000..1110 mean 512 to 3072 fs.
`timescale 1ns/10ps
`include "acrd_map.vh"
module acrd_top #(
  parameter [7:0] DIE_ID        = 8'h5A, // Arbitrary identification value
  parameter       MCLK_PRESCALE = 64     // Master clock divider, also frames per window
) (
  input  wire       clk,           // System clock, 10 MHz
  input  wire       reset_n,       // Async reset, active low
  input  wire       mclk_div_pin,  // Master clock divided by MCLK_PRESCALE
  input  wire       frame_clk_pin, // Serial audio frame clock
  input  wire       pll_enable,    // PLL in use, from same-clock logic
  input  wire [7:0] reg_addr,      // Register offset
  input  wire       reg_wr,        // Write strobe
  input  wire [7:0] reg_wdata,     // Write data
  input  wire       reg_rd,        // Read strobe
  output reg  [7:0] reg_rdata,     // Read data, valid the cycle after reg_rd
  output reg        clock_invalid  // Clock error flag
);

  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_MEAS = 2'b10;
  localparam [7:0] FRAMES  = MCLK_PRESCALE[7:0];

  wire [1:0] rise;
  wire       mclk_rise  = rise[0];
  wire       frame_rise = rise[1];

  reg  [1:0]  state_reg;
  reg  [16:0] win_cnt_reg;
  reg  [7:0]  frame_cnt_reg;
  reg  [11:0] edge_cnt_reg;
  reg  [2:0]  rate_reg;
  reg  [3:0]  ratio_reg;
  reg         resv_reg;

  acrd_sync_edge #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin_in   ({frame_clk_pin, mclk_div_pin}),
    .rise_out (rise)
  );

  // Nominal ratio for each ratio code
  function [11:0] ratio_of;
    input [3:0] code;
    begin
      case (code)
        4'h1:    ratio_of = 12'd32;
        4'h2:    ratio_of = 12'd48;
        4'h3:    ratio_of = 12'd64;
        4'h4:    ratio_of = 12'd128;
        4'h5:    ratio_of = 12'd192;
        4'h6:    ratio_of = 12'd256;
        4'h7:    ratio_of = 12'd384;
        4'h8:    ratio_of = 12'd512;
        4'h9:    ratio_of = 12'd768;
        4'hA:    ratio_of = 12'd1024;
        4'hB:    ratio_of = 12'd1152;
        4'hC:    ratio_of = 12'd1536;
        4'hD:    ratio_of = 12'd2048;
        4'hE:    ratio_of = 12'd3072;
        default: ratio_of = 12'd0;
      endcase
    end
  endfunction

  wire [11:0] win_units = win_cnt_reg[16:`ACRD_UNIT_SHIFT];

  // Sample rate band from window length
  reg [2:0] rate_next;
  always @* begin
    rate_next = `ACRD_RATE_ERR;
    if (win_units >= `ACRD_U8K_LO && win_units <= `ACRD_U8K_HI)
      rate_next = `ACRD_RATE_8K;
    else if (win_units >= `ACRD_U16K_LO && win_units <= `ACRD_U16K_HI)
      rate_next = `ACRD_RATE_16K;
    else if (win_units >= `ACRD_U48K_LO && win_units <= `ACRD_U48K_HI)
      rate_next = `ACRD_RATE_32_48K;
    else if (win_units >= `ACRD_U96K_LO && win_units <= `ACRD_U96K_HI)
      rate_next = `ACRD_RATE_88_96K;
    else if (win_units >= `ACRD_U192K_LO && win_units <= `ACRD_U192K_HI)
      rate_next = `ACRD_RATE_176_192K;
    else if (win_units >= `ACRD_U384K_LO && win_units <= `ACRD_U384K_HI)
      rate_next = `ACRD_RATE_384K;
  end

  // One comparator per ratio code; one edge of slack covers the phase of the prescaler
  wire [14:0] ratio_hit;
  assign ratio_hit[0] = 1'b0; // Code zero is the error code, never a match
  genvar g;
  generate
    for (g = 1; g <= `ACRD_RATIO_LAST; g = g + 1) begin : g_ratio
      localparam [31:0] CODE = g;
      wire [11:0] nom_w = ratio_of(CODE[3:0]);
      assign ratio_hit[g] = (edge_cnt_reg + 12'd1 >= nom_w) && (edge_cnt_reg <= nom_w + 12'd1);
    end
  endgenerate

  // Encoder over the hits; no hit leaves the ratio error code
  reg [3:0] ratio_next;
  integer   k;
  always @* begin
    ratio_next = `ACRD_RATIO_ERR;
    for (k = 1; k <= `ACRD_RATIO_LAST; k = k + 1) begin
      if (ratio_hit[k])
        ratio_next = k[3:0];
    end
  end

  // Master clock frequency check: edges*prescale/window time in us
  wire [39:0] mclk_lhs = {28'd0, edge_cnt_reg} * MCLK_PRESCALE * `ACRD_NS_PER_US;
  wire [39:0] mclk_rhs = {23'd0, win_cnt_reg} * `ACRD_MCLK_MAX_MHZ * `ACRD_CLK_PERIOD_NS;
  wire        too_fast = (mclk_lhs >= mclk_rhs);

  // Without the PLL the processor runs from the master clock, so a low ratio starves it
  wire        low_ratio = !pll_enable && (ratio_of(ratio_next) < `ACRD_MIN_RATIO_NO_PLL);
  // Valid codes can still form a bad pair, so the flag is wider than the codes
  wire        err_next = (rate_next == `ACRD_RATE_ERR) || (ratio_next == `ACRD_RATIO_ERR) ||
                         too_fast || low_ratio;

  // Window closes on the last frame edge; timeout bounds a stalled frame clock
  wire win_done = frame_rise && (frame_cnt_reg == FRAMES - 8'd1);
  wire timeout  = (win_units >= `ACRD_TIMEOUT_UNITS);

  // Measurement sequencer; a frame clock lost mid-window ends in timeout, but one absent from the start leaves it waiting in ST_WAIT
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= ST_WAIT;
      win_cnt_reg   <= 17'd0;
      frame_cnt_reg <= 8'd0;
      edge_cnt_reg  <= 12'd0;
    end else begin
      case (state_reg)
        ST_WAIT: begin
          win_cnt_reg   <= 17'd0;
          frame_cnt_reg <= 8'd0;
          edge_cnt_reg  <= 12'd0;
          if (frame_rise)
            state_reg <= ST_MEAS;
        end
        ST_MEAS: begin
          if (timeout) begin
            state_reg <= ST_WAIT;
          end else if (win_done) begin
            win_cnt_reg   <= 17'd0;
            frame_cnt_reg <= 8'd0;
            edge_cnt_reg  <= 12'd0;
          end else begin
            win_cnt_reg <= win_cnt_reg + 17'd1;
            if (frame_rise)
              frame_cnt_reg <= frame_cnt_reg + 8'd1;
            if (mclk_rise && edge_cnt_reg != 12'hFFF)
              edge_cnt_reg <= edge_cnt_reg + 12'd1;
          end
        end
        default: begin
          state_reg     <= ST_WAIT;
          win_cnt_reg   <= 17'd0;
          frame_cnt_reg <= 8'd0;
          edge_cnt_reg  <= 12'd0;
        end
      endcase
    end
  end

  // Results change only at a window end or a timeout, so a read sees one whole window
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_reg      <= `ACRD_RATE_RST;
      ratio_reg     <= `ACRD_RATIO_RST;
      clock_invalid <= 1'b0;
    end else if (state_reg == ST_MEAS && timeout) begin
      rate_reg      <= `ACRD_RATE_ERR;
      ratio_reg     <= `ACRD_RATIO_ERR;
      clock_invalid <= 1'b1;
    end else if (state_reg == ST_MEAS && win_done) begin
      rate_reg      <= rate_next;
      ratio_reg     <= ratio_next;
      clock_invalid <= err_next;
    end
  end

  // Read word chosen ahead of the edge; unmapped offsets read as zero
  reg [7:0] rdata_next;
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `ACRD_OFS_DIE_ID: rdata_next = DIE_ID;
      `ACRD_OFS_RATES:  rdata_next = {resv_reg, rate_reg, ratio_reg};
      default:          rdata_next = 8'h00;
    endcase
  end

  // Register port: writes reach only the reserved read/write bit
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resv_reg  <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `ACRD_OFS_RATES)
        resv_reg <= reg_wdata[`ACRD_RESV_BIT];
      if (reg_rd)
        reg_rdata <= rdata_next; // Holds between reads, so a slow host still sees it
    end
  end

endmodule

//--- sim/acrd_monitor.sv
/* Port checker for acrd_top: register answers and error flag pairing.
   Assumes strobes are sampled on posedge clk and rdata follows one edge later. */
`timescale 1ns/10ps
module acrd_monitor #(
  parameter [7:0] DIE_ID = 8'h5A  // Same value as the design
) (
  input wire       clk,            // System clock
  input wire       reset_n,        // Async reset, active low
  input wire       mclk_div_pin,   // Prescaled master clock
  input wire       frame_clk_pin,  // Frame clock
  input wire       pll_enable,     // PLL in use
  input wire [7:0] reg_addr,       // Register offset
  input wire       reg_wr,         // Write strobe
  input wire [7:0] reg_wdata,      // Write data
  input wire       reg_rd,         // Read strobe
  input wire [7:0] reg_rdata,      // Read data
  input wire       clock_invalid   // Clock error flag
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Fields and flag move on the same edge, so a read pairs with the flag of its edge
  property p_die_id;
    reg_rd && reg_addr == 8'h58 |=> reg_rdata == DIE_ID; endproperty
  a_die_id: assert property (p_die_id) else $error("die id read wrong");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_unmapped;
    reg_rd && reg_addr != 8'h58 && reg_addr != 8'h5B |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_rate_range;
    reg_rd && reg_addr == 8'h5B |=> reg_rdata[6:4] != 3'h7; endproperty
  a_rate_range: assert property (p_rate_range) else $error("rate code");
  property p_ratio_range;
    reg_rd && reg_addr == 8'h5B |=> reg_rdata[3:0] != 4'hF; endproperty
  a_ratio_range: assert property (p_ratio_range) else $error("ratio code");
  property p_resv_rw;
    reg_wr && !reg_rd && reg_addr == 8'h5B ##1 reg_rd && !reg_wr && reg_addr == 8'h5B
      |=> reg_rdata[7] == $past(reg_wdata[7], 2); endproperty
  a_resv_rw: assert property (p_resv_rw) else $error("bit 7 lost");
  property p_ratio_err;
    reg_rd && reg_addr == 8'h5B ##1 reg_rdata[3:0] == 4'h0 && reg_rdata[6:4] != 3'h0
      |-> $past(clock_invalid); endproperty
  a_ratio_err: assert property (p_ratio_err) else $error("ratio err unflagged");
  property p_rate_err;
    reg_rd && reg_addr == 8'h5B ##1 reg_rdata[6:4] == 3'h0 && reg_rdata[3:0] != 4'h0
      |-> $past(clock_invalid); endproperty
  a_rate_err: assert property (p_rate_err) else $error("rate err unflagged");
  c_rate_384: cover property (reg_rd && reg_addr == 8'h5B ##1 reg_rdata[6:4] == 3'h6);
  c_invalid: cover property ($rose(clock_invalid));
  c_resv: cover property (reg_wr && reg_addr == 8'h5B ##1 reg_rd);
endmodule
bind acrd_top acrd_monitor #(.DIE_ID(DIE_ID)) mon_u (.clk(clk), .reset_n(reset_n),
  .mclk_div_pin(mclk_div_pin), .frame_clk_pin(frame_clk_pin), .pll_enable(pll_enable),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clock_invalid(clock_invalid));

//--- sim/acrd_clk_source.sv
/* Audio source model: frame clock and prescaled master clock.
   Assumes the bench sets both half periods in ns; both clocks run free. */
`timescale 1ns/10ps
module acrd_clk_source (
  input  var int frame_half,  // Frame half period, ns
  input  var int mclk_half,   // Prescaled master clock half period, ns
  output reg     frame_clk,   // Frame clock
  output reg     mclk_div     // Master clock divided by 64
);
  // A new period takes hold at the next toggle, so one window may be mixed
  initial begin
    frame_clk = 1'b0;
    forever #(frame_half) frame_clk = ~frame_clk;
  end
  // Ratio and speed are whatever the bench commands, legal unless asked otherwise
  initial begin
    mclk_div = 1'b0;
    forever #(mclk_half) mclk_div = ~mclk_div;
  end
endmodule

//--- sim/acrd_bench.sv
/* Bench for acrd_top: register reads and clock sweeps with expected codes.
   Assumes the default prescale of 64, so ratio equals prescaled rises per 64-frame window. */
`timescale 1ns/10ps
module acrd_bench;
  reg        clk = 1'b0;
  reg        reset_n = 1'b0;
  reg        pll_enable = 1'b1;
  reg  [7:0] reg_addr = 8'h00;
  reg        reg_wr = 1'b0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_rd = 1'b0;
  int        frame_half = 10417;
  int        mclk_half = 2604;
  int        failures = 0;
  int        samples_checked = 0;
  wire       mclk_div_pin;
  wire       frame_clk_pin;
  wire       clock_invalid;
  wire [7:0] reg_rdata;
  acrd_top #(.DIE_ID(8'h5A)) dut_u (.clk(clk), .reset_n(reset_n), .mclk_div_pin(mclk_div_pin),
    .frame_clk_pin(frame_clk_pin), .pll_enable(pll_enable), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clock_invalid(clock_invalid));
  acrd_clk_source src_u (.frame_half(frame_half), .mclk_half(mclk_half),
    .frame_clk(frame_clk_pin), .mclk_div(mclk_div_pin));
  // Compare, count and report
  task automatic check(input [7:0] seen, input [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes go up and down on falling edges; rdata is read a full cycle late, it holds
  task automatic rd(input [7:0] a, input [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk) reg_rd = 1'b0;
    @(negedge clk) check(reg_rdata, exp, "reg_rdata");
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk) reg_wr = 1'b0;
  endtask
  // 140 frames cover a mixed window, a clean one and the old half periods running out
  task automatic run(input int fh, input int mh, input pll, input [7:0] exp, input ci);
    frame_half = fh;
    mclk_half = mh;
    pll_enable = pll;
    repeat (fh * 28 / 10) @(negedge clk);
    rd(8'h5B, exp);
    check({7'h00, clock_invalid}, {7'h00, ci}, "clock_invalid");
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  // Watchdog, above the sum of all sweeps and under 100,000 clocks
  initial begin
    #9500000;
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    rd(8'h5B, 8'h00);
    rd(8'h58, 8'h5A);
    wr(8'h58, 8'hFF);
    rd(8'h58, 8'h5A);
    rd(8'h5C, 8'h00);
    wr(8'h5B, 8'h80);
    rd(8'h5B, 8'h80);
    wr(8'h5B, 8'h00);
    run(10417, 2604, 1'b1, 8'h36, 1'b0);
    run(5208, 2604, 1'b0, 8'h44, 1'b0);
    run(5208, 3333, 1'b1, 8'h40, 1'b1);
    run(5208, 10416, 1'b0, 8'h41, 1'b1);
    run(1302, 2604, 1'b1, 8'h61, 1'b0);
    run(2604, 326, 1'b1, 8'h58, 1'b1);
    run(1000, 2000, 1'b1, 8'h01, 1'b1);
    tally_and_finish;
  end
endmodule
